// ### src/dcr_pkg.sv
`default_nettype none
package dcr_pkg;
    // Register offsets.
    localparam logic [7:0] OFS_BUS_ADDRESS_SETTING     = 8'h00;
    localparam logic [7:0] OFS_RESET_AND_POWER_CONTROL = 8'h01;
    localparam logic [7:0] OFS_OUTPUT_AND_MODE_CONFIG  = 8'h02;
    // Reset values.
    localparam logic [7:0] RST_BUS_ADDRESS_SETTING     = 8'h00;
    localparam logic [7:0] RST_RESET_AND_POWER_CONTROL = 8'h04;
    localparam logic [7:0] RST_OUTPUT_AND_MODE_CONFIG  = 8'h00;
    // Field positions in bus_address_setting.
    localparam int ADR_FIELD_LSB    = 1;
    localparam int ADR_OVERRIDE_BIT = 0;
    // Field positions in reset_and_power_control.
    localparam int RPC_AUTO_PD_BIT   = 7;
    localparam int RPC_BACK_CHAN_BIT = 2;
    localparam int RPC_FULL_RST_BIT  = 1;
    localparam int RPC_DP_RST_BIT    = 0;
    // Field positions in output_and_mode_config.
    localparam int CFG_OUT_EN_BIT      = 7;
    localparam int CFG_PIN_OVR_BIT     = 6;
    localparam int CFG_OSC_CLK_BIT     = 5;
    localparam int CFG_SLEEP_SEL_BIT   = 4;
    localparam int CFG_LEGACY_SRC_BIT  = 3;
    localparam int CFG_LEGACY_BIT      = 2;
    localparam int CFG_LOW_FREQ_SRC_BIT = 1;
    localparam int CFG_LOW_FREQ_BIT    = 0;
    // Strap address table: base address plus the strap index.
    localparam logic [6:0] STRAP_ADDR_BASE = 7'h2C;
    localparam int         STRAP_ADDR_NUM  = 16;
    // Bits per serial byte.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : dcr_pkg
`default_nettype wire

// ### src/dcr_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Serial two-wire slave answering at one of 16 strap addresses, or at the address set in offset 0x00.
// - Offset 0x00 bits 7:1 hold a readable, writable seven-bit bus address.
// - Offset 0x00 bit 0 set uses register address, clear uses the strap.
// - Offset 0x01 bit 7 powers down while no forward link is detected.
// - Offset 0x01 bit 2 enables back channel; reset value 0x04 enables it.
// - Offset 0x01 bit 1 resets all logic including registers, then self-clears.
// - Offset 0x01 bit 0 resets logic but keeps registers, then self-clears.
// - Offset 0x02 bit 7 enables parallel outputs; clear makes them high impedance.
// - Offset 0x02 bit 6 lets register enable and sleep select override pins.
// - Offset 0x02 bit 5 puts oscillator clock on pixel clock when unlocked.
// - Offset 0x02 bit 4 drives sleep state select, only when bit 6 set.
// - Offset 0x02 bit 3 takes legacy mode from bit 2, else mode strap.
// - Offset 0x02 bit 2 turns legacy compatibility on, only when bit 3 set.
// - Offset 0x02 bit 1 takes frequency range from bit 0, else mode strap.
// - Offset 0x02 bit 0 set selects low range; clear selects normal range.
module dcr_config_regs (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [3:0] address_strap_pin_i,
    input  wire logic       mode_strap_legacy_i,
    input  wire logic       mode_strap_low_freq_i,
    input  wire logic       output_enable_pin_i,
    input  wire logic       output_sleep_state_select_i,
    input  wire logic       link_detect_i,
    input  wire logic       lock_i,
    output logic            power_down_o,
    output logic            back_channel_en_o,
    output logic            datapath_soft_reset_o,
    output logic            output_enable_o,
    output logic            output_sleep_state_select_o,
    output logic            osc_clk_on_pclk_o,
    output logic            legacy_compat_mode_o,
    output logic            low_freq_range_mode_o
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV, ST_DEV_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } dcr_state_e;

    dcr_state_e state, next_state;
    logic       scl_q, sda_q, next_scl_q, next_sda_q;
    logic [7:0] shift, next_shift;
    logic [7:0] tx, next_tx;
    logic [3:0] cnt, next_cnt;
    logic [7:0] ptr, next_ptr;
    logic       rw, next_rw;
    logic       oe, next_oe;
    logic       wr_stb;
    logic       rise, fall, start_ev, stop_ev;
    logic [6:0] active_addr;

    logic [7:0] addr_reg, next_addr_reg;
    logic       auto_pd, next_auto_pd;
    logic       bchan_en, next_bchan_en;
    logic [7:0] cfg, next_cfg;
    logic       next_power_down, next_dp_rst, next_out_en, next_sleep_sel;
    logic       next_osc_clk, next_legacy, next_low_freq;

    function automatic logic [7:0] rd_data(input logic [7:0] a);
        case (a)
            dcr_pkg::OFS_BUS_ADDRESS_SETTING:     rd_data = addr_reg;
            dcr_pkg::OFS_RESET_AND_POWER_CONTROL: rd_data = {auto_pd, 4'h0, bchan_en, 2'h0};
            dcr_pkg::OFS_OUTPUT_AND_MODE_CONFIG:  rd_data = cfg;
            default:                              rd_data = 8'h00;
        endcase
    endfunction

    // The strap index picks one of the consecutive table addresses.
    assign active_addr = addr_reg[dcr_pkg::ADR_OVERRIDE_BIT] ? addr_reg[7:dcr_pkg::ADR_FIELD_LSB]
                       : 7'(dcr_pkg::STRAP_ADDR_BASE + {3'h0, address_strap_pin_i});

    assign rise     = scl_i & ~scl_q;
    assign fall     = ~scl_i & scl_q;
    assign start_ev = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_ev  = scl_i & scl_q & ~sda_q & sda_i;
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe;

    // Serial slave: bits are sampled on the rising clock edge and driven after the falling one.
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_tx    = tx;
        next_cnt   = cnt;
        next_ptr   = ptr;
        next_rw    = rw;
        next_oe    = oe;
        next_scl_q = scl_i;
        next_sda_q = sda_i;
        wr_stb     = 1'b0;
        if (start_ev) begin
            next_state = ST_DEV;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
        end else if (stop_ev) begin
            next_state = ST_IDLE;
            next_oe    = 1'b0;
        end else begin
            case (state)
                ST_DEV, ST_PTR, ST_WR: begin
                    if (rise) begin
                        next_shift = {shift[6:0], sda_i};
                        next_cnt   = cnt + 4'h1;
                    end else if (fall && cnt == dcr_pkg::BITS_PER_BYTE) begin
                        next_oe = 1'b1;
                        if (state == ST_DEV) begin
                            if (shift[7:1] == active_addr) begin
                                next_state = ST_DEV_ACK;
                                next_rw    = shift[0];
                            end else begin
                                next_state = ST_IDLE;
                                next_oe    = 1'b0;
                            end
                        end else if (state == ST_PTR) begin
                            next_ptr   = shift;
                            next_state = ST_PTR_ACK;
                        end else begin
                            wr_stb     = 1'b1;
                            next_state = ST_WR_ACK;
                        end
                    end
                end
                ST_DEV_ACK, ST_PTR_ACK, ST_WR_ACK: begin
                    if (fall) begin
                        next_cnt = 4'h0;
                        if (state == ST_DEV_ACK && rw) begin
                            next_tx    = rd_data(ptr);
                            next_oe    = ~next_tx[7];
                            next_state = ST_RD;
                        end else begin
                            next_oe    = 1'b0;
                            next_state = (state == ST_DEV_ACK) ? ST_PTR : ST_WR;
                            if (state == ST_WR_ACK) begin
                                next_ptr = ptr + 8'h01;
                            end
                        end
                    end
                end
                ST_RD: begin
                    if (rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (fall) begin
                        if (cnt == dcr_pkg::BITS_PER_BYTE) begin
                            next_oe    = 1'b0;
                            next_state = ST_RD_ACK;
                        end else begin
                            next_tx = {tx[6:0], 1'b0};
                            next_oe = ~tx[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (rise && sda_i) begin
                        next_state = ST_IDLE;
                    end else if (fall) begin
                        next_ptr   = ptr + 8'h01;
                        next_tx    = rd_data(ptr + 8'h01);
                        next_oe    = ~next_tx[7];
                        next_cnt   = 4'h0;
                        next_state = ST_RD;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_oe    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            tx    <= 8'h00;
            cnt   <= 4'h0;
            ptr   <= 8'h00;
            rw    <= 1'b0;
            oe    <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state <= next_state;
            shift <= next_shift;
            tx    <= next_tx;
            cnt   <= next_cnt;
            ptr   <= next_ptr;
            rw    <= next_rw;
            oe    <= next_oe;
            scl_q <= next_scl_q;
            sda_q <= next_sda_q;
        end
    end

    // Register bank and the registered controls that it steers.
    always_comb begin
        next_addr_reg = addr_reg;
        next_auto_pd  = auto_pd;
        next_bchan_en = bchan_en;
        next_cfg      = cfg;
        next_dp_rst   = 1'b0;
        if (wr_stb) begin
            case (ptr)
                dcr_pkg::OFS_BUS_ADDRESS_SETTING: begin
                    next_addr_reg = shift;
                end
                dcr_pkg::OFS_RESET_AND_POWER_CONTROL: begin
                    // Reset bits are never stored, so they always read back as zero.
                    if (shift[dcr_pkg::RPC_FULL_RST_BIT]) begin
                        next_addr_reg = dcr_pkg::RST_BUS_ADDRESS_SETTING;
                        next_auto_pd  =
                            dcr_pkg::RST_RESET_AND_POWER_CONTROL[dcr_pkg::RPC_AUTO_PD_BIT];
                        next_bchan_en =
                            dcr_pkg::RST_RESET_AND_POWER_CONTROL[dcr_pkg::RPC_BACK_CHAN_BIT];
                        next_cfg      = dcr_pkg::RST_OUTPUT_AND_MODE_CONFIG;
                        next_dp_rst   = 1'b1;
                    end else begin
                        next_auto_pd  = shift[dcr_pkg::RPC_AUTO_PD_BIT];
                        next_bchan_en = shift[dcr_pkg::RPC_BACK_CHAN_BIT];
                        next_dp_rst   = shift[dcr_pkg::RPC_DP_RST_BIT];
                    end
                end
                dcr_pkg::OFS_OUTPUT_AND_MODE_CONFIG: begin
                    next_cfg = shift;
                end
                default: begin
                    next_cfg = cfg;
                end
            endcase
        end
        next_power_down = auto_pd & ~link_detect_i;
        next_out_en     = cfg[dcr_pkg::CFG_PIN_OVR_BIT] ? cfg[dcr_pkg::CFG_OUT_EN_BIT]
                        : output_enable_pin_i;
        next_sleep_sel  = cfg[dcr_pkg::CFG_PIN_OVR_BIT] ? cfg[dcr_pkg::CFG_SLEEP_SEL_BIT]
                        : output_sleep_state_select_i;
        next_osc_clk    = cfg[dcr_pkg::CFG_OSC_CLK_BIT] & ~lock_i;
        next_legacy     = cfg[dcr_pkg::CFG_LEGACY_SRC_BIT] ? cfg[dcr_pkg::CFG_LEGACY_BIT]
                        : mode_strap_legacy_i;
        next_low_freq   = cfg[dcr_pkg::CFG_LOW_FREQ_SRC_BIT] ? cfg[dcr_pkg::CFG_LOW_FREQ_BIT]
                        : mode_strap_low_freq_i;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_reg                    <= dcr_pkg::RST_BUS_ADDRESS_SETTING;
            auto_pd                     <= 1'b0;
            bchan_en                    <= 1'b1;
            cfg                         <= dcr_pkg::RST_OUTPUT_AND_MODE_CONFIG;
            power_down_o                <= 1'b0;
            back_channel_en_o           <= 1'b1;
            datapath_soft_reset_o       <= 1'b0;
            output_enable_o             <= 1'b0;
            output_sleep_state_select_o <= 1'b0;
            osc_clk_on_pclk_o           <= 1'b0;
            legacy_compat_mode_o        <= 1'b0;
            low_freq_range_mode_o       <= 1'b0;
        end else begin
            addr_reg                    <= next_addr_reg;
            auto_pd                     <= next_auto_pd;
            bchan_en                    <= next_bchan_en;
            cfg                         <= next_cfg;
            power_down_o                <= next_power_down;
            back_channel_en_o           <= bchan_en;
            datapath_soft_reset_o       <= next_dp_rst;
            output_enable_o             <= next_out_en;
            output_sleep_state_select_o <= next_sleep_sel;
            osc_clk_on_pclk_o           <= next_osc_clk;
            legacy_compat_mode_o        <= next_legacy;
            low_freq_range_mode_o       <= next_low_freq;
        end
    end
endmodule : dcr_config_regs
`default_nettype wire

// ### test/dcr_config_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dcr_config_regs_assertions (
    input wire logic       mclk_i,
    input wire logic       rst_b_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [3:0] address_strap_pin_i,
    input wire logic       mode_strap_legacy_i,
    input wire logic       mode_strap_low_freq_i,
    input wire logic       output_enable_pin_i,
    input wire logic       output_sleep_state_select_i,
    input wire logic       link_detect_i,
    input wire logic       lock_i,
    input wire logic       power_down_o,
    input wire logic       back_channel_en_o,
    input wire logic       datapath_soft_reset_o,
    input wire logic       output_enable_o,
    input wire logic       output_sleep_state_select_o,
    input wire logic       osc_clk_on_pclk_o,
    input wire logic       legacy_compat_mode_o,
    input wire logic       low_freq_range_mode_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Bus writes land only after scl has been seen low twice.
    sequence s_scl_low2;
        !scl_i && !$past(scl_i);
    endsequence
    a_pd_no_link: assert property (power_down_o |-> !$past(link_detect_i))
        else $error("power down with link");
    a_osc_unlocked: assert property (osc_clk_on_pclk_o |-> !$past(lock_i))
        else $error("osc clock while locked");
    a_back_chan_reset: assert property ($rose(rst_b_i) |-> back_channel_en_o)
        else $error("back channel off");
    a_soft_pulse_one: assert property (datapath_soft_reset_o |=> !datapath_soft_reset_o)
        else $error("soft reset too long");
    a_soft_pulse_bus: assert property (datapath_soft_reset_o |-> s_scl_low2)
        else $error("soft reset off bus");
    a_drive_scl_low: assert property ($changed(sda_oe_o) |-> s_scl_low2)
        else $error("sda moved in scl high");
    a_oe_source: assert property ($changed(output_enable_o) |->
        output_enable_o == $past(output_enable_pin_i) || !scl_i)
        else $error("output enable source");
    a_legacy_source: assert property ($changed(legacy_compat_mode_o) |->
        legacy_compat_mode_o == $past(mode_strap_legacy_i) || !scl_i)
        else $error("legacy source");
    a_freq_source: assert property ($changed(low_freq_range_mode_o) |->
        low_freq_range_mode_o == $past(mode_strap_low_freq_i) || !scl_i)
        else $error("freq range source");
endmodule  // dcr_config_regs_assertions
bind dcr_config_regs dcr_config_regs_assertions dcr_config_regs_assertions_inst (.*);
`default_nettype wire

// ### test/dcr_bus_host.sv
`timescale 1ns/10ps
`default_nettype none
module dcr_bus_host (
    input  wire logic mclk_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    // The wire has a pull-up, so a released line reads high.
    logic pull = 1'b0;
    assign sda_o = ~(pull | sda_oe_i);
    initial scl_o = 1'b1;
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        pull = ~b;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        r = sda_o;
        tick(2);
        scl_o = 1'b0;
    endtask
    // Start when st is 1, stop when 0; sda is set up while scl is low, then moves again while scl is high.
    task automatic edge_cond(input logic st);
        tick(2);
        pull = ~st;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        pull = st;
        tick(4);
        scl_o = ~st;
    endtask
    task automatic put(input logic [7:0] d, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ok = ok & ~r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                      output logic ok);
        ok = 1'b1;
        edge_cond(1'b1);
        put({a, 1'b0}, ok);
        if (ok) begin
            put(o, ok);
            put(d, ok);
        end
        edge_cond(1'b0);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d);
        logic ok;
        logic r;
        ok = 1'b1;
        edge_cond(1'b1);
        put({a, 1'b0}, ok);
        put(o, ok);
        edge_cond(1'b1);
        put({a, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, r);
        edge_cond(1'b0);
        if (!ok) d = 8'hXX;
    endtask
endmodule  // dcr_bus_host
`default_nettype wire

// ### test/dcr_config_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dcr_config_regs_tb;
    localparam logic [6:0] A = dcr_pkg::STRAP_ADDR_BASE;
    logic       mclk  = 1'b0;
    logic       rst_b = 1'b0;
    logic       scl;
    logic       sda;
    logic       sda_oe;
    logic       sda_dev;
    logic [3:0] strap = 4'h0;
    logic [5:0] pin   = 6'h3E;
    wire logic [7:0] outs;
    logic [7:0] rdat;
    logic       ok;
    int         mismatches = 0;
    int         checked    = 0;
    int         pulses     = 0;
    int         cycles     = 0;
    logic [7:0] cv [7] = '{8'h40, 8'hD0, 8'h2A, 8'h0E, 8'h0B, 8'h05, 8'hFE};
    always #12.5 mclk = ~mclk;
    // The device may only pull the wire low, so a driven high value must not reach it.
    dcr_bus_host dcr_bus_host_inst (.mclk_i(mclk), .sda_oe_i(sda_oe & ~sda_dev), .scl_o(scl),
                                    .sda_o(sda));
    dcr_config_regs dcr_config_regs_inst (
        .mclk_i(mclk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_dev),
        .sda_oe_o(sda_oe), .address_strap_pin_i(strap), .mode_strap_legacy_i(pin[3]),
        .mode_strap_low_freq_i(pin[2]), .output_enable_pin_i(pin[5]),
        .output_sleep_state_select_i(pin[4]), .link_detect_i(pin[1]), .lock_i(pin[0]),
        .power_down_o(outs[7]), .back_channel_en_o(outs[6]),
        .datapath_soft_reset_o(outs[5]), .output_enable_o(outs[4]),
        .output_sleep_state_select_o(outs[3]), .osc_clk_on_pclk_o(outs[2]),
        .legacy_compat_mode_o(outs[1]), .low_freq_range_mode_o(outs[0]));
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                      input logic ak);
        dcr_bus_host_inst.wr(a, o, d, ok);
        chk(8'(ok), 8'(ak));
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] o, input logic [7:0] e);
        dcr_bus_host_inst.rd(a, o, rdat);
        chk(rdat, e);
    endtask
    // Expected outputs with power down off and the back channel on.
    function automatic logic [7:0] exp_out(input logic [7:0] c);
        return {2'b01, 1'b0, c[6] ? c[7] : pin[5], c[6] ? c[4] : pin[4],
                c[5] & ~pin[0], c[3] ? c[2] : pin[3], c[1] ? c[0] : pin[2]};
    endfunction
    always @(posedge mclk) begin
        cycles++;
        pulses += int'(outs[5] === 1'b1);
        if (cycles == 60000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        rd(A, 8'h00, 8'h00);
        rd(A, 8'h01, 8'h04);
        chk(outs, exp_out(8'h00));
        foreach (cv[i]) begin
            wr(A, 8'h02, cv[i], 1'b1);
            chk(outs, exp_out(cv[i]));
            rd(A, 8'h02, cv[i]);
        end
        pin[0] = 1'b1;
        pin[5:4] = 2'b00;
        repeat (2) @(negedge mclk);
        chk(outs, exp_out(8'hFE));
        wr(A, 8'h01, 8'h84, 1'b1);
        pin[1] = 1'b0;
        repeat (2) @(negedge mclk);
        chk(8'(outs[7]), 8'h01);
        pin[1] = 1'b1;
        wr(A, 8'h01, 8'h78, 1'b1);
        chk(8'(outs[7:6]), 8'h00);
        rd(A, 8'h01, 8'h00);
        wr(A, 8'h01, 8'h05, 1'b1);
        chk(8'(pulses), 8'h01);
        rd(A, 8'h02, 8'hFE);
        rd(A, 8'h01, 8'h04);
        wr(A, 8'h01, 8'h02, 1'b1);
        chk(8'(pulses), 8'h02);
        rd(A, 8'h02, 8'h00);
        wr(A, 8'h05, 8'hA5, 1'b1);
        rd(A, 8'h05, 8'h00);
        wr(A, 8'h00, 8'h23, 1'b1);
        rd(7'h11, 8'h00, 8'h23);
        wr(A, 8'h02, 8'h80, 1'b0);
        wr(7'h11, 8'h00, 8'h00, 1'b1);
        strap = 4'hF;
        rd(7'h3B, 8'h02, 8'h00);
        end_of_test();
    end
endmodule  // dcr_config_regs_tb
`default_nettype wire
